// >>> verilog/lfwr_ctrl.sv
// Functional notes
// - Continuous mode without toggle keeps the receiver active while receiver_on stays set, until a message completes.
// - Sample interval code 0000 selects continuous operation.
// - Continuous mode restarts itself 2-3 slow periods after a processed message.
// - In continuous mode, toggle mode stops after each on-time, inverts carrier mode, restarts.
// - Trim value, once written, holds until the next full reset.
// - The block decodes eight consecutive register addresses.
// - Setting receiver_on powers up for one full slow period from next rise.
// - receiver_on 0 means standby, 1 active; resets to 0, read/write.
// - Writing soft reset starts a receiver reset; bit self-clears, reads zero.
// - Carrier mode bit selects data receive or carrier detect operation.
// - Carrier detect sets carrier_seen_flag and requests interrupt when enabled.
// - Page select banks wake id registers only; receiver reset clears it.
// - Wake id select: none, 8-bit low, 16-bit both, 8-bit either.
// - A message is accepted only when the received id matches; wake id select none accepts any id.
// - Sensitivity code drives only the carrier detect threshold.
`include "lfwr_defines.svh"

module lfwr_ctrl (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic slow_timebase_osc_in,
  input wire lfwr_pkg::lfwr_bus_s bus_in,
  input wire lfwr_pkg::lfwr_rx_s rx_in,
  output logic [7:0] rd_data_out,
  output lfwr_pkg::lfwr_cfg_s cfg_out,
  output logic msg_accept_out,
  output logic carrier_irq_out,
  output logic soft_reset_out
);
  import lfwr_pkg::*;

  // ==========================================================
  // Storage
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;
  logic [1:0] flags_r;
  logic [7:0] trim_r;
  logic trim_locked_r;
  logic [1:0] ctl3_r;
  logic [7:0] wake_id_low_r;
  logic [7:0] wake_id_high_r;
  logic [7:0] rd_data_r;
  logic soft_reset_req_r;
  logic osc_prev_r;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  lfwr_state_e state_r;
  lfwr_state_e state_nxt;
  logic toggle_nxt;
  logic accept;

  // ==========================================================
  // Decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic in_block = (bus_in.addr & `LFWR_BLOCK_MASK) == `LFWR_BLOCK_BASE;
  wire logic wr = bus_in.wr && in_block;
  wire logic wr_ctl1 = wr && hit(bus_in.addr, `LFWR_OFS_CTL1);
  wire logic wr_ctl2 = wr && hit(bus_in.addr, `LFWR_OFS_CTL2);
  wire logic wr_flags = wr && hit(bus_in.addr, `LFWR_OFS_FLAGS);
  wire logic wr_trim = wr && hit(bus_in.addr, `LFWR_OFS_TRIM);
  wire logic wr_ctl3 = wr && hit(bus_in.addr, `LFWR_OFS_CTL3);
  wire logic wr_id = wr && hit(bus_in.addr, `LFWR_OFS_WAKE_ID);
  wire logic page = ctl1_r[`LFWR_CTL1_PAGE];
  wire logic rx_on = ctl1_r[`LFWR_CTL1_ON];
  wire logic car_mode = ctl1_r[`LFWR_CTL1_CARMODE];
  wire logic [1:0] id_sel = ctl1_r[`LFWR_CTL1_IDSEL_HI:`LFWR_CTL1_IDSEL_LO];
  wire logic [3:0] interval_sel = ctl2_r[7:4];
  wire logic [3:0] on_time_sel = ctl2_r[3:0];
  wire logic continuous = (interval_sel == `LFWR_SEL_CONTINUOUS);
  wire logic osc_rise = slow_timebase_osc_in && !osc_prev_r;
  wire logic soft_rst = soft_reset_req_r;
  wire logic ready = (state_r == LFWR_ACTIVE);
  wire logic powered = (state_r != LFWR_OFF) && (state_r != LFWR_GAP);

  // Sleep length in slow periods for sampled mode; large codes saturate
  wire logic [11:0] sleep_len = (interval_sel > 4'h8) ? 12'h0800 :
    12'(`LFWR_BASE_INTERVAL) << (interval_sel - 4'h1);
  wire logic [11:0] on_len = {8'h00, on_time_sel} + 12'h001;
  wire logic on_time_done = osc_rise && (cnt_r + 12'h001 >= on_len);

  // ==========================================================
  // Receiver sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    toggle_nxt = 1'b0;
    case (state_r)
      LFWR_OFF: begin
        if (rx_on) begin
          state_nxt = LFWR_WAIT_EDGE;
        end
      end
      LFWR_WAIT_EDGE: begin
        if (osc_rise) begin
          state_nxt = LFWR_PWRUP;
        end
      end
      LFWR_PWRUP: begin
        if (osc_rise) begin
          state_nxt = LFWR_AUTOZERO;
          cnt_nxt = 12'h000;
        end
      end
      LFWR_AUTOZERO: begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == 12'(`LFWR_AZ_CYCLES - 1)) begin
          state_nxt = LFWR_ACTIVE;
          cnt_nxt = 12'h000;
        end
      end
      LFWR_ACTIVE: begin
        if (osc_rise) begin
          cnt_nxt = cnt_r + 12'h001;
        end
        if (rx_in.msg_done) begin
          state_nxt = LFWR_GAP;
          cnt_nxt = 12'h000;
        end else if (on_time_done && (!continuous || ctl3_r[`LFWR_CTL3_TOGGLE])) begin
          state_nxt = LFWR_GAP;
          cnt_nxt = 12'h000;
          toggle_nxt = continuous;
        end
      end
      LFWR_GAP: begin
        if (osc_rise) begin
          cnt_nxt = cnt_r + 12'h001;
          if (cnt_r + 12'h001 >= (continuous ? 12'(`LFWR_GAP_EDGES) : sleep_len)) begin
            state_nxt = LFWR_PWRUP;
          end
        end
      end
      default: begin
        state_nxt = LFWR_OFF;
        cnt_nxt = 12'h000;
      end
    endcase
    // Dropping receiver_on always wins: standby from any state
    if (!rx_on) begin
      state_nxt = LFWR_OFF;
      cnt_nxt = 12'h000;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in || (ce_in && soft_rst)) begin
      state_r <= LFWR_OFF;
      cnt_r <= 12'h000;
    end else if (ce_in) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Registers
  // Soft reset is delayed one cycle, so the write that raises it lands first and is then cleared with the rest of ctl1
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      soft_reset_req_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else if (ce_in) begin
      soft_reset_req_r <= wr_ctl1 && bus_in.wdata[`LFWR_CTL1_SOFT_RESET_REQ];
      osc_prev_r <= slow_timebase_osc_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || (ce_in && soft_rst)) begin
      ctl1_r <= `LFWR_CTL1_RST;
      ctl2_r <= `LFWR_CTL2_RST;
      ctl3_r <= 2'b00;
      wake_id_low_r <= 8'h00;
      wake_id_high_r <= 8'h00;
    end else if (ce_in) begin
      if (wr_ctl1) begin
        ctl1_r <= bus_in.wdata & ~(8'h01 << `LFWR_CTL1_SOFT_RESET_REQ);
      end else if (toggle_nxt) begin
        ctl1_r[`LFWR_CTL1_CARMODE] <= !car_mode;
      end
      if (wr_ctl2) begin
        ctl2_r <= bus_in.wdata;
      end
      if (wr_ctl3) begin
        ctl3_r <= bus_in.wdata[1:0];
      end
      if (wr_id && !page) begin
        wake_id_low_r <= bus_in.wdata;
      end
      if (wr_id && page) begin
        wake_id_high_r <= bus_in.wdata;
      end
    end
  end

  // Trim survives soft reset; only the full reset reopens it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trim_r <= `LFWR_TRIM_RST;
      trim_locked_r <= 1'b0;
    end else if (ce_in && wr_trim && !trim_locked_r) begin
      trim_r <= bus_in.wdata;
      trim_locked_r <= 1'b1;
    end
  end

  // Hardware set wins over a same-cycle write-one-to-clear
  wire logic car_set = ready && car_mode && rx_in.carrier_det;
  wire logic [1:0] flag_set = {accept, car_set};
  wire logic [1:0] flag_clr = wr_flags ? bus_in.wdata[1:0] : 2'b00;
  always_ff @(posedge mclk_in) begin
    if (rst_in || (ce_in && soft_rst)) begin
      flags_r <= 2'b00;
    end else if (ce_in) begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  lfwr_id_match u_id_match (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .id_sel_in(id_sel),
    .id_low_in(wake_id_low_r),
    .id_high_in(wake_id_high_r),
    .id_valid_in(rx_in.id_valid && ready && !car_mode),
    .id_rx_in(rx_in.id),
    .accept_out(accept)
  );

  // ==========================================================
  // Read path
  wire logic [7:0] rd_mux =
    hit(bus_in.addr, `LFWR_OFS_CTL1) ? ctl1_r :
    hit(bus_in.addr, `LFWR_OFS_CTL2) ? ctl2_r :
    hit(bus_in.addr, `LFWR_OFS_FLAGS) ? {6'h00, flags_r} :
    hit(bus_in.addr, `LFWR_OFS_TRIM) ? trim_r :
    hit(bus_in.addr, `LFWR_OFS_CTL3) ? {6'h00, ctl3_r} :
    hit(bus_in.addr, `LFWR_OFS_WAKE_ID) ? (page ? wake_id_high_r : wake_id_low_r) :
    hit(bus_in.addr, `LFWR_OFS_STATUS) ? {5'h00, state_r == LFWR_GAP, powered, ready} :
    8'h00;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_data_r <= 8'h00;
    end else if (ce_in && bus_in.rd) begin
      rd_data_r <= in_block ? rd_mux : 8'h00;
    end
  end
  assign rd_data_out = rd_data_r;
  assign cfg_out = '{powered: powered, ready: ready, carrier_mode: car_mode,
                     threshold: ctl1_r[`LFWR_CTL1_SENS_HI:`LFWR_CTL1_SENS_LO],
                     trim: trim_r};
  assign msg_accept_out = accept;
  assign carrier_irq_out = flags_r[`LFWR_FLAG_CARRIER] && ctl3_r[`LFWR_CTL3_IRQ_EN];
  assign soft_reset_out = soft_reset_req_r;

  // ==========================================================
  // Checks
  standby_when_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && !rx_on && !soft_rst |=> state_r == LFWR_OFF) else $error("not standby when off");
  pwrup_on_edge_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && state_r == LFWR_WAIT_EDGE && rx_on && !soft_rst && osc_rise
    |=> state_r == LFWR_PWRUP) else $error("power-up not on slow rise");
  autozero_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && state_r == LFWR_ACTIVE && $past(state_r) == LFWR_AUTOZERO
    |-> $past(cnt_r) == 12'(`LFWR_AZ_CYCLES - 1)) else $error("auto-zero length wrong");
  cont_stays_on_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && ready && continuous && rx_on && !soft_rst && !rx_in.msg_done
    && !ctl3_r[`LFWR_CTL3_TOGGLE] |=> ready) else $error("continuous receiver dropped");
  gap_restart_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == LFWR_PWRUP && $past(state_r) == LFWR_GAP && continuous
    |-> $past(cnt_r) == 12'(`LFWR_GAP_EDGES - 1)) else $error("restart gap wrong");
  toggle_flip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && toggle_nxt && !wr_ctl1 && !soft_rst |=> car_mode != $past(car_mode))
    else $error("carrier mode not toggled");
  trim_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    trim_locked_r |=> $stable(trim_r)) else $error("trim changed after lock");
  soft_reset_req_reads_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !ctl1_r[`LFWR_CTL1_SOFT_RESET_REQ]) else $error("soft reset bit stored");
  soft_clears_page_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && soft_rst |=> !page && state_r == LFWR_OFF) else $error("soft reset incomplete");
  carrier_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && car_set && !soft_rst |=> flags_r[`LFWR_FLAG_CARRIER]) else $error("carrier lost");
  odd_addr_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && bus_in.rd && !in_block |=> rd_data_out == 8'h00) else $error("unmapped read");
  reach_active_c: cover property (@(posedge mclk_in) state_r == LFWR_ACTIVE);
  gap_restart_c: cover property (@(posedge mclk_in) state_r == LFWR_GAP ##1 state_r == LFWR_PWRUP);
  toggle_c: cover property (@(posedge mclk_in) toggle_nxt);
  irq_c: cover property (@(posedge mclk_in) carrier_irq_out);

endmodule : lfwr_ctrl

// >>> verilog/lfwr_defines.svh
`ifndef LFWR_DEFINES_SVH
`define LFWR_DEFINES_SVH

// ==========================================================
// Register offsets (eight consecutive addresses)
`define LFWR_OFS_CTL1 8'h20
`define LFWR_OFS_CTL2 8'h21
`define LFWR_OFS_FLAGS 8'h22
`define LFWR_OFS_TRIM 8'h23
`define LFWR_OFS_CTL3 8'h24
`define LFWR_OFS_WAKE_ID 8'h25
`define LFWR_OFS_STATUS 8'h26
`define LFWR_OFS_SPARE 8'h27
`define LFWR_BLOCK_BASE 8'h20
`define LFWR_BLOCK_MASK 8'hF8

// ==========================================================
// Field positions
`define LFWR_CTL1_ON 7
`define LFWR_CTL1_SOFT_RESET_REQ 6
`define LFWR_CTL1_CARMODE 5
`define LFWR_CTL1_PAGE 4
`define LFWR_CTL1_IDSEL_HI 3
`define LFWR_CTL1_IDSEL_LO 2
`define LFWR_CTL1_SENS_HI 1
`define LFWR_CTL1_SENS_LO 0
`define LFWR_FLAG_CARRIER 0
`define LFWR_FLAG_ACCEPT 1
`define LFWR_CTL3_IRQ_EN 0
`define LFWR_CTL3_TOGGLE 1

// ==========================================================
// Reset values
`define LFWR_CTL1_RST 8'h00
`define LFWR_CTL2_RST 8'h60
`define LFWR_TRIM_RST 8'h00
`define LFWR_SEL_CONTINUOUS 4'h0

// ==========================================================
// Timing
`define LFWR_CLK_PERIOD_NS 40
`define LFWR_AZ_TIME_US 64
`define LFWR_AZ_CYCLES (((`LFWR_AZ_TIME_US * 1000) + `LFWR_CLK_PERIOD_NS - 1) / `LFWR_CLK_PERIOD_NS)
`define LFWR_GAP_EDGES 3
`define LFWR_BASE_INTERVAL 16

`endif

// >>> verilog/lfwr_pkg.sv
package lfwr_pkg;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    LFWR_OFF = 6'b00_0001,
    LFWR_WAIT_EDGE = 6'b00_0010,
    LFWR_PWRUP = 6'b00_0100,
    LFWR_AUTOZERO = 6'b00_1000,
    LFWR_ACTIVE = 6'b01_0000,
    LFWR_GAP = 6'b10_0000
  } lfwr_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lfwr_bus_s;

  typedef struct packed {
    logic carrier_det;
    logic msg_done;
    logic id_valid;
    logic [15:0] id;
  } lfwr_rx_s;

  typedef struct packed {
    logic powered;
    logic ready;
    logic carrier_mode;
    logic [1:0] threshold;
    logic [7:0] trim;
  } lfwr_cfg_s;

endpackage : lfwr_pkg

// >>> verilog/lfwr_id_match.sv
`include "lfwr_defines.svh"

module lfwr_id_match (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [1:0] id_sel_in,
  input wire logic [7:0] id_low_in,
  input wire logic [7:0] id_high_in,
  input wire logic id_valid_in,
  input wire logic [15:0] id_rx_in,
  output logic accept_out
);
  import lfwr_pkg::*;

  function automatic logic id_hit(input logic [1:0] sel, input logic [7:0] lo,
                                  input logic [7:0] hi, input logic [15:0] rx);
    case (sel)
      2'b00: id_hit = 1'b1;
      2'b01: id_hit = (rx[7:0] == lo);
      2'b10: id_hit = (rx == {hi, lo});
      2'b11: id_hit = (rx[7:0] == lo) || (rx[7:0] == hi);
      default: id_hit = 1'b0;
    endcase
  endfunction : id_hit

  logic accept_r;
  wire logic hit = id_valid_in && id_hit(id_sel_in, id_low_in, id_high_in, id_rx_in);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      accept_r <= 1'b0;
    end else if (ce_in) begin
      accept_r <= hit;
    end
  end

  assign accept_out = accept_r;

  // ==========================================================
  // Checks
  wide_id_match_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && id_valid_in && id_sel_in == 2'b10 && id_rx_in != {id_high_in, id_low_in}
    |=> !accept_out) else $error("16-bit id accepted on mismatch");
  accept_cause_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    accept_out |-> $past(id_valid_in)) else $error("accept without received id");

endmodule : lfwr_id_match

// >>> sim/lfwr_front_model.sv
module lfwr_front_model #(
  parameter int SLOW_HALF = 100
) (
  input wire logic mclk_in,
  output logic slow_osc_out,
  output lfwr_pkg::lfwr_rx_s rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfwr_pkg::*;

  // ==========================================================
  // Slow timebase, shortened so a power cycle fits the run
  int slow_cnt = 0;
  initial begin
    slow_osc_out = 1'b0;
    rx_out = '0;
  end
  always @(negedge mclk_in) begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1) begin
      slow_osc_out <= ~slow_osc_out;
    end
  end

  // ==========================================================
  // Front-end events, one clock wide
  task automatic pulse_carrier();
    @(negedge mclk_in);
    rx_out.carrier_det = 1'b1;
    @(negedge mclk_in);
    rx_out.carrier_det = 1'b0;
  endtask : pulse_carrier

  task automatic send_id(input logic [15:0] id);
    @(negedge mclk_in);
    rx_out.id = id;
    rx_out.id_valid = 1'b1;
    @(negedge mclk_in);
    rx_out.id_valid = 1'b0;
    // Id is not held after the strobe: show something else
    rx_out.id = ~id;
  endtask : send_id

  task automatic end_msg();
    @(negedge mclk_in);
    rx_out.msg_done = 1'b1;
    @(negedge mclk_in);
    rx_out.msg_done = 1'b0;
  endtask : end_msg
endmodule : lfwr_front_model

// >>> sim/lf_wake_receiver_control_test.sv
module lf_wake_receiver_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lfwr_pkg::*;
  localparam int HALF = 100;
  localparam int SLOW = 2 * HALF;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic slow_osc;
  lfwr_bus_s bus = '0;
  lfwr_rx_s rx;
  logic [7:0] rd_data;
  lfwr_cfg_s cfg;
  logic accept;
  logic irq;
  logic soft_reset_req;
  wire [2:0] mon = {irq, accept, soft_reset_req};
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] v;
  logic [7:0] id_lo;
  logic [7:0] id_hi;
  logic [15:0] cand [4];
  int n;
  int cyc;

  always #20 mclk_in = ~mclk_in;

  lfwr_ctrl i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
    .slow_timebase_osc_in(slow_osc), .bus_in(bus), .rx_in(rx), .rd_data_out(rd_data),
    .cfg_out(cfg), .msg_accept_out(accept), .carrier_irq_out(irq), .soft_reset_out(soft_reset_req));
  lfwr_front_model #(.SLOW_HALF(HALF)) i_fe (.mclk_in(mclk_in), .slow_osc_out(slow_osc),
    .rx_out(rx));

  // ==========================================================
  // Reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ==========================================================
  // Register access and waits
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge mclk_in);
    bus.wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge mclk_in);
    bus.rd = 1'b0;
    d = rd_data;
  endtask : reg_rd

  // Polls powered (which 0) or ready (which 1); a hang ends the run
  task automatic wait_for(input int which, input logic lvl, input int limit, output int c);
    c = 0;
    while ((which ? cfg.ready : cfg.powered) !== lvl) begin
      @(negedge mclk_in);
      c++;
      if (c > limit) begin
        miscompares++;
        $display("BAD wait %0d timed out", which);
        finish_test();
      end
    end
  endtask : wait_for

  task automatic count_mon(input int b, input int len, output int c);
    c = 0;
    repeat (len) begin
      c += (mon[b] === 1'b1);
      @(negedge mclk_in);
    end
  endtask : count_mon

  task automatic power_on(input logic [7:0] ctl1);
    int c;
    reg_wr(8'h20, ctl1);
    wait_for(1, 1'b1, 2 * SLOW + 1620, c);
    check("ready delay", c >= SLOW + 1590, 1);
  endtask : power_on

  // Turns off and keeps the receiver idle two slow periods
  task automatic power_off();
    reg_wr(8'h20, 8'h00);
    repeat (2 * SLOW + 4) @(negedge mclk_in);
  endtask : power_off

  function automatic logic exp_accept(input logic [1:0] sel, input logic [15:0] r);
    case (sel)
      2'b00: return 1'b1;
      2'b01: return r[7:0] == id_lo;
      2'b10: return r == {id_hi, id_lo};
      default: return r[7:0] == id_lo || r[7:0] == id_hi;
    endcase
  endfunction : exp_accept

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(62265));
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    reg_rd(8'h20, v);
    check("ctl1 reset", v, 16'h0000);
    reg_rd(8'h21, v);
    check("ctl2 reset", v, 16'h0060);
    reg_rd(8'h27, v);
    check("last addr", v, 16'h0000);
    reg_rd(8'h28, v);
    check("unmapped", v, 16'h0000);
    check("standby", cfg.powered, 0);
    for (n = 0; n < 6; n++) begin
      v = 8'($urandom) & 8'h3F;
      reg_wr(8'h20, v);
      reg_rd(8'h20, id_lo);
      check("ctl1 fields", id_lo, v);
      check("threshold", cfg.threshold, v[1:0]);
      check("carrier mode", cfg.carrier_mode, v[5]);
    end
    v = 8'($urandom);
    reg_wr(8'h23, v);
    reg_wr(8'h23, ~v);
    reg_rd(8'h23, id_lo);
    check("trim", id_lo, v);
    reg_wr(8'h20, 8'h5F);
    count_mon(0, 4, n);
    check("soft pulse", n, 1);
    reg_rd(8'h20, id_lo);
    check("ctl1 soft", id_lo, 16'h0000);
    check("trim kept", cfg.trim, v);
    // Clock enable low: a write to the enable bit must not land
    ce_in = 1'b0;
    reg_wr(8'h20, 8'h80);
    ce_in = 1'b1;
    reg_rd(8'h20, id_lo);
    check("ce freeze", id_lo, 16'h0000);
    check("ce standby", cfg.powered, 0);
    // Continuous carrier detect with interrupt
    reg_wr(8'h21, 8'h00);
    reg_wr(8'h22, 8'hFF);
    reg_wr(8'h24, 8'h01);
    power_on(8'hA1);
    check("no early irq", irq, 0);
    repeat (4 * SLOW) @(negedge mclk_in);
    check("stays ready", cfg.ready, 1);
    i_fe.pulse_carrier();
    @(negedge mclk_in);
    check("carrier irq", irq, 1);
    reg_rd(8'h22, v);
    check("carrier flag", v[0], 1);
    reg_wr(8'h22, 8'h01);
    check("irq cleared", irq, 0);
    power_off();
    // Data mode: every id length, matching and not
    id_lo = 8'($urandom);
    id_hi = 8'($urandom);
    reg_wr(8'h24, 8'h00);
    reg_wr(8'h25, id_lo);
    reg_wr(8'h20, 8'h10);
    reg_wr(8'h25, id_hi);
    reg_rd(8'h25, v);
    check("id page1", v, id_hi);
    reg_rd(8'h21, v);
    check("ctl2 unpaged", v, 16'h0000);
    reg_wr(8'h20, 8'h00);
    reg_rd(8'h25, v);
    check("id page0", v, id_lo);
    for (int s = 0; s < 4; s++) begin
      cand = '{{id_hi, id_lo}, {~id_hi, id_lo}, {8'h00, id_hi}, 16'($urandom)};
      power_on({4'h8, 2'(s), 2'b10});
      for (int k = 0; k < 4; k++) begin
        i_fe.send_id(cand[k]);
        count_mon(1, 4, n);
        check("accept", n, exp_accept(2'(s), cand[k]));
      end
      i_fe.end_msg();
      wait_for(0, 1'b0, 3, cyc);
      wait_for(0, 1'b1, 3 * SLOW + 4, cyc);
      check("restart gap", cyc >= 2 * SLOW - 4, 1);
      wait_for(1, 1'b1, 2 * SLOW + 1620, cyc);
      power_off();
    end
    // Toggle mode flips the carrier mode between on-times
    reg_wr(8'h21, 8'h01);
    reg_wr(8'h24, 8'h02);
    power_on(8'h80);
    wait_for(0, 1'b0, 3 * SLOW, cyc);
    check("toggled", cfg.carrier_mode, 1);
    wait_for(1, 1'b1, 5 * SLOW + 1620, cyc);
    power_off();
    // Sampled mode: two-rise on-time, then sixteen slow periods asleep
    reg_wr(8'h21, 8'h11);
    reg_wr(8'h24, 8'h00);
    power_on(8'h80);
    wait_for(0, 1'b0, 3 * SLOW, cyc);
    check("sampled on time", cyc >= 2 * SLOW - 4, 1);
    wait_for(0, 1'b1, 16 * SLOW + 4, cyc);
    check("sampled sleep", cyc >= 16 * SLOW - 4, 1);
    power_off();
    finish_test();
  end
endmodule : lf_wake_receiver_control_test
